// File: hdl/service_flow_classifier.sv
`timescale 1ns/100ps
`default_nettype none

// ***********************************
// Output-registered FIFO
// ***********************************
module sfc_fifo #(
   parameter int W = 48,
   parameter int D = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wrPtr_r, rdPtr_r;
   logic [AW:0] count_r, count_nxt;
   logic inReady_r, outValid_r;
   logic [W-1:0] outData_r;
   logic push, pop;

   assign push = inValid && inReady_r;
   assign pop = (!outValid_r || outReady) && (count_r != '0);
   assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign inReady = inReady_r;
   assign outValid = outValid_r;
   assign outData = outData_r;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_r] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
         inReady_r <= 1'b0;
      end else begin
         wrPtr_r <= wrPtr_r + AW'(push);
         rdPtr_r <= rdPtr_r + AW'(pop);
         count_r <= count_nxt;
         inReady_r <= count_nxt != (AW+1)'(D);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         outValid_r <= 1'b0;
         outData_r <= '0;
      end else if (pop) begin
         outValid_r <= 1'b1;
         outData_r <= mem[rdPtr_r];
      end else if (outReady) begin
         outValid_r <= 1'b0;
      end
   end

   property p_full;
      @(posedge clk) disable iff (!rst_n) count_r == (AW+1)'(D) |-> !inReady_r;
   endproperty
   a_full: assert property (p_full) else $error("fifo accepts while full");
endmodule

// ***********************************
// Classifier and flow state
// ***********************************
module service_flow_classifier (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pktValid,
   output logic pktReady,
   input wire logic pktDir,
   input wire logic pktHasIp,
   input wire logic pktHasLlc,
   input wire logic pktHasTag,
   input wire logic [7:0] pktTos,
   input wire logic [7:0] pktProto,
   input wire logic [31:0] pktSrcIp,
   input wire logic [31:0] pktDstIp,
   input wire logic [15:0] pktSrcPort,
   input wire logic [15:0] pktDstPort,
   input wire logic [sfc_pkg::MAC_W-1:0] pktDstMac,
   input wire logic [sfc_pkg::MAC_W-1:0] pktSrcMac,
   input wire logic [sfc_pkg::ETH_W-1:0] pktEthType,
   input wire logic [sfc_pkg::UP_W-1:0] pktUserPrio,
   input wire logic [sfc_pkg::VLAN_W-1:0] pktVlan,
   input wire logic [sfc_pkg::TAG_W-1:0] pktTag,
   output logic outValid,
   input wire logic outReady,
   output logic [sfc_pkg::ID_W-1:0] outFlowId,
   output logic [sfc_pkg::TAG_W-1:0] outTag,
   output logic dropPulse,
   input wire logic clsWrValid,
   input wire logic clsFromMgmt,
   input wire logic clsApprove,
   input wire logic [sfc_pkg::EW-1:0] clsIndex,
   input wire logic [3:0] clsField,
   input wire logic [sfc_pkg::FLD_W-1:0] clsData,
   output logic clsDone,
   output logic clsOk,
   input wire logic cmdValid,
   input wire sfc_pkg::cmd_t cmd,
   input wire logic [sfc_pkg::FW-1:0] cmdSlot,
   input wire logic [sfc_pkg::ID_W-1:0] cmdFlowId,
   input wire logic cmdDir,
   input wire logic [sfc_pkg::IDX_W-1:0] cmdIndex,
   input wire sfc_pkg::qos_t cmdQos,
   input wire logic dynAuth,
   input wire sfc_pkg::qos_t envQos,
   input wire logic authApprove,
   output logic cmdDone,
   output logic cmdOk,
   output logic [sfc_pkg::NFLOW-1:0] flowLive,
   output logic [sfc_pkg::NFLOW-1:0] flowAdmitted
);
   import sfc_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic [FLD_W-1:0] fld_r [NENT][NFLD];
   logic [NENT-1:0] dyn_r;
   logic [NFLOW-1:0] exist_r, dir_r, provP_r, resP_r, liveP_r;
   logic [ID_W-1:0] fid_r [NFLOW];
   logic [IDX_W-1:0] upIdx_r [NFLOW];
   qos_t prov_r [NFLOW];
   qos_t res_r [NFLOW];
   qos_t live_r [NFLOW];
   logic [NENT-1:0] hit;
   logic [NENT-1:0] anyRel;
   logic [NENT-1:0] usable;
   logic found;
   logic [EW-1:0] bestIdx;
   logic [PRIO_W-1:0] bestPrio;
   logic [FW-1:0] selSlot;
   logic drop, fire, fifoIn;
   logic dropPulse_r, clsDone_r, clsOk_r, cmdDone_r, cmdOk_r;
   logic cmdAcc, clsAcc, envOk;
   logic [NCRIT-1:0] rel;

   // ***********************************
   // Per-entry match
   // ***********************************
   assign rel = {{2{pktHasTag}}, {3{pktHasLlc}}, {6{pktHasIp}}};

   for (genvar i = 0; i < NENT; i++) begin : g_ent
      logic [FLD_W-1:0] ctl, tos, sip, dip, spt, dpt, upr;
      logic [NCRIT-1:0] m, en;
      logic [7:0] mt;
      logic [FW-1:0] slot;
      assign ctl = fld_r[i][F_CTRL];
      assign en = fld_r[i][F_EN][NCRIT-1:0];
      assign slot = ctl[C_SLOT +: FW];
      assign tos = fld_r[i][F_CRIT0+K_TOS];
      assign sip = fld_r[i][F_CRIT0+K_SIP];
      assign dip = fld_r[i][F_CRIT0+K_DIP];
      assign spt = fld_r[i][F_CRIT0+K_SPT];
      assign dpt = fld_r[i][F_CRIT0+K_DPT];
      assign upr = fld_r[i][F_CRIT0+K_UPRI];
      assign mt = pktTos & tos[B_MSK +: 8];
      // Network-layer criteria
      assign m[K_TOS] = (mt >= tos[7:0]) && (mt <= tos[B_HI +: 8]);
      assign m[K_PROTO] = pktProto == fld_r[i][F_CRIT0+K_PROTO][7:0];
      assign m[K_SIP] = ((pktSrcIp ^ sip[31:0]) & pfxMask(sip[IP_LEN +: 6])) == '0;
      assign m[K_DIP] = ((pktDstIp ^ dip[31:0]) & pfxMask(dip[IP_LEN +: 6])) == '0;
      assign m[K_SPT] = (pktSrcPort >= spt[15:0]) && (pktSrcPort <= spt[PT_END +: 16]);
      assign m[K_DPT] = (pktDstPort >= dpt[15:0]) && (pktDstPort <= dpt[PT_END +: 16]);
      // Link-layer and tag criteria
      assign m[K_DMAC] = pktDstMac == fld_r[i][F_CRIT0+K_DMAC];
      assign m[K_SMAC] = pktSrcMac == fld_r[i][F_CRIT0+K_SMAC];
      assign m[K_ETH] = pktEthType == fld_r[i][F_CRIT0+K_ETH][ETH_W-1:0];
      assign m[K_UPRI] = (pktUserPrio >= upr[UP_W-1:0]) && (pktUserPrio <= upr[UP_W +: UP_W]);
      assign m[K_VLAN] = pktVlan == fld_r[i][F_CRIT0+K_VLAN][VLAN_W-1:0];
      // Entry and its flow both live, same direction
      assign usable[i] = ctl[C_VALID] && ctl[C_ACT] && liveP_r[slot] && (dir_r[slot] == pktDir);
      assign anyRel[i] = |(en & rel);
      assign hit[i] = anyRel[i] && ((m | ~(en & rel)) == '1) && usable[i];

      property p_relev;
         hit[i] |-> anyRel[i];
      endproperty
      a_relev: assert property (p_relev) else $error("hit without relevant criteria");
      property p_usable;
         hit[i] |-> ctl[C_ACT] && liveP_r[slot];
      endproperty
      a_usable: assert property (p_usable) else $error("hit on unusable entry");
   end

   // ***********************************
   // Priority search
   // ***********************************
   always_comb begin
      found = 1'b0;
      bestIdx = '0;
      bestPrio = '0;
      for (int i = 0; i < NENT; i++) begin
         // Strictly greater keeps lowest index on ties
         if (hit[i] && (!found || fld_r[i][F_CTRL][PRIO_W-1:0] > bestPrio)) begin
            found = 1'b1;
            bestIdx = EW'(i);
            bestPrio = fld_r[i][F_CTRL][PRIO_W-1:0];
         end
      end
   end

   always_comb begin
      if (found) begin
         selSlot = fld_r[bestIdx][F_CTRL][C_SLOT +: FW];
      end else if (pktDir == DIR_UP) begin
         selSlot = PRI_UP;
      end else begin
         selSlot = PRI_DN;
      end
   end

   // Only flows with a live set carry traffic
   assign drop = !liveP_r[selSlot];
   assign fire = pktValid && pktReady;
   assign fifoIn = pktValid && !drop;

   sfc_fifo #(.W(ID_W + TAG_W), .D(DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(fifoIn),
      .inReady(pktReady),
      .inData({fid_r[selSlot], pktTag}),
      .outValid(outValid),
      .outReady(outReady),
      .outData({outFlowId, outTag})
   );

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dropPulse_r <= 1'b0;
      end else begin
         dropPulse_r <= fire && drop;
      end
   end
   assign dropPulse = dropPulse_r;

   // ***********************************
   // Classifier table writes
   // ***********************************
   // Dynamic entries are closed to management every change approved
   assign clsAcc = clsWrValid && clsApprove && !(clsFromMgmt && dyn_r[clsIndex]);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NENT; i++) begin
            for (int f = 0; f < NFLD; f++) begin
               fld_r[i][f] <= '0;
            end
         end
         dyn_r <= '0;
      end else begin
         if (clsAcc && clsField < 4'(NFLD)) begin
            fld_r[clsIndex][clsField] <= clsData;
            if (clsField == F_CTRL) begin
               dyn_r[clsIndex] <= !clsFromMgmt;
            end
         end
         // Deleting a flow takes its entries with it
         for (int i = 0; i < NENT; i++) begin
            if (cmdAcc && cmd == CMD_DEL && fld_r[i][F_CTRL][C_SLOT +: FW] == cmdSlot) begin
               fld_r[i][F_CTRL][C_VALID] <= 1'b0;
               dyn_r[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         clsDone_r <= 1'b0;
         clsOk_r <= 1'b0;
      end else begin
         clsDone_r <= clsWrValid;
         clsOk_r <= clsAcc && clsField < 4'(NFLD);
      end
   end
   assign clsDone = clsDone_r;
   assign clsOk = clsOk_r;

   // ***********************************
   // Flow commands
   // ***********************************
   // Envelope: authorized set or provisioned set
   assign envOk = dynAuth ? subset(cmdQos, envQos) : (provP_r[cmdSlot] && subset(cmdQos, prov_r[cmdSlot]));

   always_comb begin
      unique case (cmd)
         CMD_REG, CMD_DYN: cmdAcc = !exist_r[cmdSlot];
         CMD_ADMIT: cmdAcc = exist_r[cmdSlot] && envOk
            && (!liveP_r[cmdSlot] || subset(live_r[cmdSlot], cmdQos));
         CMD_ACT: cmdAcc = exist_r[cmdSlot] && resP_r[cmdSlot]
            && subset(cmdQos, res_r[cmdSlot]);
         CMD_DEACT, CMD_DEL: cmdAcc = exist_r[cmdSlot];
         default: cmdAcc = 1'b0;
      endcase
      cmdAcc = cmdAcc && cmdValid && authApprove;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         exist_r <= '0;
         dir_r <= '0;
         provP_r <= '0;
         resP_r <= '0;
         liveP_r <= '0;
         for (int s = 0; s < NFLOW; s++) begin
            fid_r[s] <= '0;
            upIdx_r[s] <= '0;
            prov_r[s] <= '0;
            res_r[s] <= '0;
            live_r[s] <= '0;
         end
      end else if (cmdAcc) begin
         unique case (cmd)
            CMD_REG, CMD_DYN: begin
               // Existence starts with the assigned identifier
               exist_r[cmdSlot] <= 1'b1;
               fid_r[cmdSlot] <= cmdFlowId;
               dir_r[cmdSlot] <= cmdDir;
               provP_r[cmdSlot] <= cmd == CMD_REG;
               prov_r[cmdSlot] <= (cmd == CMD_REG) ? cmdQos : '0;
            end
            CMD_ADMIT: begin
               resP_r[cmdSlot] <= 1'b1;
               res_r[cmdSlot] <= cmdQos;
               if (dir_r[cmdSlot] == DIR_UP) begin
                  upIdx_r[cmdSlot] <= cmdIndex;
               end
            end
            CMD_ACT: begin
               liveP_r[cmdSlot] <= 1'b1;
               live_r[cmdSlot] <= cmdQos;
            end
            CMD_DEACT: begin
               liveP_r[cmdSlot] <= 1'b0;
               live_r[cmdSlot] <= '0;
            end
            CMD_DEL: begin
               exist_r[cmdSlot] <= 1'b0;
               provP_r[cmdSlot] <= 1'b0;
               resP_r[cmdSlot] <= 1'b0;
               liveP_r[cmdSlot] <= 1'b0;
               upIdx_r[cmdSlot] <= '0;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmdDone_r <= 1'b0;
         cmdOk_r <= 1'b0;
      end else begin
         cmdDone_r <= cmdValid;
         cmdOk_r <= cmdAcc;
      end
   end
   assign cmdDone = cmdDone_r;
   assign cmdOk = cmdOk_r;
   assign flowLive = liveP_r;
   assign flowAdmitted = resP_r;

   // ***********************************
   // Checks
   // ***********************************
   for (genvar s = 0; s < NFLOW; s++) begin : g_chk
      property p_index;
         !(resP_r[s] || liveP_r[s]) |-> upIdx_r[s] == '0;
      endproperty
      a_index: assert property (p_index) else $error("index held for idle flow");
   end

   sequence s_regTaken;
      cmdValid && authApprove && cmd == CMD_REG && !exist_r[cmdSlot];
   endsequence
   sequence s_dynTaken;
      cmdValid && authApprove && cmd == CMD_DYN && !exist_r[cmdSlot];
   endsequence
   property p_dynNull;
      s_dynTaken |=> !provP_r[$past(cmdSlot)] && cmdDone && cmdOk;
   endproperty
   a_dynNull: assert property (p_dynNull) else $error("dynamic flow got provisioned set");
   property p_regProv;
      s_regTaken |=> provP_r[$past(cmdSlot)] && exist_r[$past(cmdSlot)];
   endproperty
   a_regProv: assert property (p_regProv) else $error("registration left set null");
   property p_nak;
      cmdValid && !authApprove |=> cmdDone && !cmdOk;
   endproperty
   a_nak: assert property (p_nak) else $error("unapproved change accepted");
   property p_mgmt;
      clsWrValid && clsFromMgmt && dyn_r[clsIndex] |=> clsDone && !clsOk;
   endproperty
   a_mgmt: assert property (p_mgmt) else $error("management changed dynamic entry");
   property p_dflt;
      fire && !found && pktDir == DIR_UP |-> selSlot == PRI_UP;
   endproperty
   a_dflt: assert property (p_dflt) else $error("unmatched packet not on primary");
   property p_dropLive;
      fire && !liveP_r[selSlot] |=> dropPulse;
   endproperty
   a_dropLive: assert property (p_dropLive) else $error("inactive flow not dropped");
   property p_pushLive;
      fire && !drop |-> liveP_r[selSlot];
   endproperty
   a_pushLive: assert property (p_pushLive) else $error("forward on inactive flow");
endmodule

`default_nettype wire

// File: hdl/sfc_pkg.sv
package sfc_pkg;
   // ***********************************
   // Sizes
   // ***********************************
   localparam int NENT = 8;
   localparam int EW = 3;
   localparam int NFLOW = 4;
   localparam int FW = 2;
   localparam int DEPTH = 16;
   localparam int FLD_W = 48;
   localparam int NFLD = 13;
   localparam int NCRIT = 11;
   localparam int ID_W = 32;
   localparam int IDX_W = 14;
   localparam int PAR_W = 16;
   localparam int SCH_W = 3;
   localparam int TAG_W = 16;
   localparam int PRIO_W = 8;
   // ***********************************
   // Field codes and positions
   // ***********************************
   localparam logic [3:0] F_CTRL = 4'h0;
   localparam logic [3:0] F_EN = 4'h1;
   localparam int F_CRIT0 = 2;
   localparam int C_SLOT = 8;
   localparam int C_ACT = 10;
   localparam int C_VALID = 11;
   localparam int B_HI = 8;
   localparam int B_MSK = 16;
   localparam int IP_LEN = 32;
   localparam int PT_END = 16;
   localparam int UP_W = 3;
   localparam int VLAN_W = 12;
   localparam int ETH_W = 16;
   localparam int MAC_W = 48;
   localparam int K_TOS = 0;
   localparam int K_PROTO = 1;
   localparam int K_SIP = 2;
   localparam int K_DIP = 3;
   localparam int K_SPT = 4;
   localparam int K_DPT = 5;
   localparam int K_DMAC = 6;
   localparam int K_SMAC = 7;
   localparam int K_ETH = 8;
   localparam int K_UPRI = 9;
   localparam int K_VLAN = 10;
   localparam logic [FW-1:0] PRI_UP = 2'h0;
   localparam logic [FW-1:0] PRI_DN = 2'h1;
   localparam logic DIR_UP = 1'b0;
   localparam logic [5:0] IP_FULL = 6'h20;

   typedef enum logic [2:0] {
      CMD_REG = 3'b000,
      CMD_DYN = 3'b001,
      CMD_ADMIT = 3'b010,
      CMD_ACT = 3'b011,
      CMD_DEACT = 3'b100,
      CMD_DEL = 3'b101
   } cmd_t;

   typedef struct packed {
      logic [SCH_W-1:0] sched;
      logic [PAR_W-1:0] intv;
      logic [PAR_W-1:0] jit;
      logic [PAR_W-1:0] rate;
   } qos_t;

   function automatic logic subset(input qos_t a, input qos_t b);
      logic mult;
      mult = (b.intv != '0) && ((a.intv % b.intv) == '0);
      subset = (a.rate <= b.rate) && (a.jit >= b.jit) && mult && (a.sched == b.sched);
   endfunction

   function automatic logic [31:0] pfxMask(input logic [5:0] len);
      pfxMask = (len >= IP_FULL) ? 32'hffffffff : ~(32'hffffffff >> len);
   endfunction
endpackage

// File: hdl/unused_placeholder_none.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// File: tb/pkt_sink_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***********************************
// Result consumer with stall modes
// ***********************************
module pkt_sink_model (
   input wire logic clk,
   input wire logic [1:0] mode,
   output logic outReady
);
   // Mode 0 stalls, 1 always takes, 2 takes at random
   initial outReady = 1'b0;
   always @(posedge clk) begin
      outReady <= (mode == 2'h1) || (mode == 2'h2 && $urandom_range(1) == 1);
   end
endmodule
`default_nettype wire

// File: tb/test_service_flow_classifier.sv
`timescale 1ns/100ps
`default_nettype none
module test_service_flow_classifier;
   import sfc_pkg::*;
   // ***********************************
   // Signals and reference state
   // ***********************************
   logic clk, rst_n, pktValid, pktReady, pktDir, pktHasIp, pktHasLlc, pktHasTag, outValid;
   logic outReady, dropPulse, clsWrValid, clsFromMgmt, clsApprove, clsDone, clsOk, cmdValid;
   logic cmdDir, dynAuth, authApprove, cmdDone, cmdOk;
   logic [7:0] pktTos, pktProto;
   logic [31:0] pktSrcIp, pktDstIp;
   logic [15:0] pktSrcPort, pktDstPort;
   logic [MAC_W-1:0] pktDstMac, pktSrcMac;
   logic [ETH_W-1:0] pktEthType;
   logic [UP_W-1:0] pktUserPrio;
   logic [VLAN_W-1:0] pktVlan;
   logic [TAG_W-1:0] pktTag, outTag;
   logic [ID_W-1:0] outFlowId, cmdFlowId;
   logic [EW-1:0] clsIndex;
   logic [3:0] clsField;
   logic [FLD_W-1:0] clsData;
   cmd_t cmd;
   logic [FW-1:0] cmdSlot;
   logic [IDX_W-1:0] cmdIndex;
   qos_t cmdQos, envQos, q, good, bq;
   logic [NFLOW-1:0] flowLive, flowAdmitted, liveM, admM;
   logic [1:0] sinkMode;
   logic [ID_W-1:0] fidM [NFLOW];
   logic dirM [NFLOW];
   logic [11:0] ctrlM [NENT];
   logic [7:0] protoM [NENT];
   logic enM [NENT];
   logic [47:0] expQ [$];
   int n_mismatch, n_tests, nDrop, expDrop;

   service_flow_classifier service_flow_classifier_inst (.*);
   pkt_sink_model pkt_sink_model_inst (.clk(clk), .mode(sinkMode), .outReady(outReady));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      end_of_test();
   end

   always @(posedge clk) begin
      if (dropPulse === 1'b1)
         nDrop++;
      if (rst_n && outValid === 1'b1 && outReady === 1'b1)
         check({outFlowId, outTag}, expQ.size() > 0 ? expQ.pop_front() : 'x);
   end
   // ***********************************
   // Tasks and reference functions
   // ***********************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Highest priority wins, lowest index on a tie, else primary flow
   function automatic int expSlot(input logic ip, input logic [7:0] p, input logic d);
      int best;
      best = -1;
      for (int i = 0; i < NENT; i++) begin
         if (ctrlM[i][C_VALID] && ctrlM[i][C_ACT] && liveM[ctrlM[i][9:8]] && enM[i] && ip
             && dirM[ctrlM[i][9:8]] == d && protoM[i] == p
             && (best < 0 || ctrlM[i][7:0] > ctrlM[best][7:0]))
            best = i;
      end
      return (best < 0) ? int'(d ? PRI_DN : PRI_UP) : int'(ctrlM[best][9:8]);
   endfunction

   task automatic send(input logic ip, input logic [7:0] p, input logic d);
      int s;
      s = expSlot(ip, p, d);
      @(negedge clk);
      pktValid = 1'b1;
      pktHasIp = ip;
      pktProto = p;
      pktDir = d;
      {pktHasLlc, pktHasTag, pktTos, pktUserPrio, pktVlan} = 25'($urandom);
      {pktSrcPort, pktDstPort} = $urandom;
      {pktTag, pktEthType} = $urandom;
      {pktDstMac, pktSrcMac} = {$urandom, $urandom, $urandom};
      {pktSrcIp, pktDstIp} = {$urandom, $urandom};
      for (int k = 0; k < 200; k++) begin
         @(posedge clk);
         if (pktReady === 1'b1)
            break;
      end
      if (liveM[s])
         expQ.push_back({fidM[s], pktTag});
      else
         expDrop++;
      @(negedge clk);
      pktValid = 1'b0;
   endtask

   task automatic drain();
      for (int k = 0; k < 500 && expQ.size() > 0; k++)
         @(negedge clk);
      repeat (4) @(negedge clk);
      check(expQ.size(), 0);
      check(nDrop, expDrop);
   endtask

   task automatic burst(input int n);
      logic [7:0] p;
      repeat (n) begin
         p = ($urandom_range(2) == 0) ? 8'h06 : ($urandom_range(1) ? 8'h11 : 8'($urandom));
         send($urandom_range(3) != 0, p, 1'($urandom));
      end
      drain();
   endtask

   task automatic cmdGo(input cmd_t c, input int s, input logic d, input qos_t qq,
                        input logic ok);
      @(negedge clk);
      cmdValid = 1'b1;
      cmd = c;
      cmdSlot = s[FW-1:0];
      cmdDir = d;
      cmdQos = qq;
      cmdFlowId = 32'h5f000000 + s;
      cmdIndex = 14'($urandom);
      @(negedge clk);
      check({cmdDone, cmdOk}, {1'b1, ok});
      cmdValid = 1'b0;
      if (ok) begin
         case (c)
            CMD_REG, CMD_DYN: begin
               fidM[s] = cmdFlowId;
               dirM[s] = d;
            end
            CMD_ADMIT: admM[s] = 1'b1;
            CMD_ACT: liveM[s] = 1'b1;
            CMD_DEACT: liveM[s] = 1'b0;
            default: begin
               {liveM[s], admM[s]} = 2'h0;
               for (int i = 0; i < NENT; i++)
                  if (ctrlM[i][9:8] == s[1:0])
                     ctrlM[i][C_VALID] = 1'b0;
            end
         endcase
      end
      check({flowAdmitted, flowLive}, {admM, liveM});
   endtask

   task automatic clsGo(input int i, input logic [3:0] f, input logic [FLD_W-1:0] dt,
                        input logic m, input logic ap, input logic ok);
      @(negedge clk);
      clsWrValid = 1'b1;
      clsIndex = i[EW-1:0];
      clsField = f;
      clsData = dt;
      clsFromMgmt = m;
      clsApprove = ap;
      @(negedge clk);
      check({clsDone, clsOk}, {1'b1, ok});
      clsWrValid = 1'b0;
      if (ok && f == F_CTRL)
         ctrlM[i] = dt[11:0];
      if (ok && f == F_EN)
         enM[i] = dt[K_PROTO];
      if (ok && f == 4'h3)
         protoM[i] = dt[7:0];
   endtask

   task automatic setEntry(input int i, input logic [7:0] pr, input int s, input logic act,
                           input logic en, input logic [7:0] p, input logic m);
      clsGo(i, F_EN, en ? 48'h2 : 48'h0, m, 1'b1, 1'b1);
      clsGo(i, 4'h3, {40'h0, p}, m, 1'b1, 1'b1);
      clsGo(i, F_CTRL, {36'h0, 1'b1, act, s[1:0], pr}, m, 1'b1, 1'b1);
   endtask
   // ***********************************
   // Main sequence
   // ***********************************
   initial begin
      {pktValid, pktDir, pktHasIp, pktHasLlc, pktHasTag, clsWrValid, clsFromMgmt} = '0;
      {cmdValid, cmdDir, dynAuth, rst_n, sinkMode, pktTos, pktProto, pktTag} = '0;
      {pktSrcIp, pktDstIp, pktSrcPort, pktDstPort, pktDstMac, pktSrcMac} = '0;
      {pktEthType, pktUserPrio, pktVlan, clsIndex, clsField, clsData, cmdSlot} = '0;
      {cmdQos, envQos, cmdFlowId, cmdIndex, liveM, admM} = '0;
      {clsApprove, authApprove} = 2'h3;
      cmd = CMD_REG;
      for (int i = 0; i < NENT; i++) begin
         ctrlM[i] = '0;
         enM[i] = 1'b0;
      end
      q = '{sched: 3'h1, intv: 16'h000a, jit: 16'h0005, rate: 16'h0100};
      good = '{sched: 3'h1, intv: 16'h0014, jit: 16'h0006, rate: 16'h0080};
      void'($urandom(32'hd332));
      repeat (4) @(negedge clk);
      check({pktReady, outValid, dropPulse, clsDone, cmdDone, flowLive, flowAdmitted}, '0);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      check(pktReady, 1'b1);
      sinkMode = 2'h2;
      cmdGo(CMD_ACT, 0, DIR_UP, q, 1'b0);
      cmdGo(CMD_REG, 0, DIR_UP, q, 1'b1);
      cmdGo(CMD_REG, 0, DIR_UP, q, 1'b0);
      cmdGo(CMD_ADMIT, 0, DIR_UP, q, 1'b1);
      cmdGo(CMD_ACT, 0, DIR_UP, q, 1'b1);
      cmdGo(CMD_REG, 1, ~DIR_UP, q, 1'b1);
      cmdGo(CMD_ADMIT, 1, ~DIR_UP, q, 1'b1);
      cmdGo(CMD_ACT, 1, ~DIR_UP, q, 1'b1);
      cmdGo(CMD_DYN, 2, DIR_UP, q, 1'b1);
      cmdGo(CMD_DYN, 3, DIR_UP, q, 1'b1);
      cmdGo(CMD_ADMIT, 2, DIR_UP, good, 1'b0);
      dynAuth = 1'b1;
      envQos = q;
      for (int b = 0; b < 4; b++) begin
         bq = good;
         case (b)
            0: bq.rate = 16'h0101;
            1: bq.jit = 16'h0004;
            2: bq.intv = 16'h000f;
            default: bq.sched = 3'h2;
         endcase
         cmdGo(CMD_ADMIT, 2, DIR_UP, bq, 1'b0);
      end
      authApprove = 1'b0;
      cmdGo(CMD_ADMIT, 2, DIR_UP, good, 1'b0);
      authApprove = 1'b1;
      cmdGo(CMD_ADMIT, 2, DIR_UP, good, 1'b1);
      setEntry(0, 8'h05, 2, 1'b1, 1'b1, 8'h06, 1'b0);
      setEntry(1, 8'h09, 3, 1'b1, 1'b1, 8'h06, 1'b0);
      setEntry(2, 8'hc8, 2, 1'b0, 1'b1, 8'h11, 1'b0);
      setEntry(3, 8'h05, 0, 1'b1, 1'b1, 8'h06, 1'b1);
      setEntry(4, 8'h03, 1, 1'b1, 1'b1, 8'h06, 1'b1);
      setEntry(5, 8'hfa, 2, 1'b1, 1'b0, 8'h06, 1'b0);
      burst(24);
      cmdGo(CMD_ACT, 2, DIR_UP, q, 1'b0);
      cmdGo(CMD_ACT, 2, DIR_UP, good, 1'b1);
      burst(24);
      sinkMode = 2'h0;
      repeat (17)
         send(1'b1, 8'h06, DIR_UP);
      @(negedge clk);
      check(pktReady, 1'b0);
      sinkMode = 2'h1;
      drain();
      sinkMode = 2'h2;
      cmdGo(CMD_ADMIT, 3, DIR_UP, q, 1'b1);
      cmdGo(CMD_ACT, 3, DIR_UP, q, 1'b1);
      burst(24);
      clsGo(0, F_CTRL, 48'h0, 1'b1, 1'b1, 1'b0);
      clsGo(4, 4'hd, 48'h0, 1'b1, 1'b1, 1'b0);
      clsGo(4, 4'h3, 48'h6, 1'b1, 1'b0, 1'b0);
      cmdGo(CMD_DEACT, 0, DIR_UP, q, 1'b1);
      burst(24);
      cmdGo(CMD_DEL, 3, DIR_UP, q, 1'b1);
      cmdGo(CMD_DEL, 3, DIR_UP, q, 1'b0);
      burst(24);
      end_of_test();
   end
endmodule
`default_nettype wire
